/* File: ptg_buf2.sv */
`timescale 1ns/1ps
`default_nettype none
module ptg_buf2 (
	input  wire logic     i_core_clk,
	input  wire logic     i_rst,
	ptg_strm_if.dst       s_in,
	ptg_strm_if.src       s_out
);
	// ----------------------------------------------------------------
	// two-entry skid: head register feeds the ports, spare catches a stall
	// ----------------------------------------------------------------
	logic               out_v_ff;
	logic               nxt_out_v;
	logic               sk_v_ff;
	logic               nxt_sk_v;
	ptg_pkg::ptg_beat_t out_d_ff;
	ptg_pkg::ptg_beat_t nxt_out_d;
	ptg_pkg::ptg_beat_t sk_d_ff;
	ptg_pkg::ptg_beat_t nxt_sk_d;
	logic               take;
	logic               pop;

	assign s_in.ready  = ~sk_v_ff;
	assign s_out.valid = out_v_ff;
	assign s_out.beat  = out_d_ff;
	assign take        = s_in.valid & ~sk_v_ff;
	assign pop         = out_v_ff & s_out.ready;

	always_comb begin
		nxt_out_v = out_v_ff;
		nxt_out_d = out_d_ff;
		nxt_sk_v  = sk_v_ff;
		nxt_sk_d  = sk_d_ff;
		if (pop) begin
			if (sk_v_ff) begin
				nxt_out_d = sk_d_ff;
				nxt_sk_v  = 1'b0;
			end else if (take) begin
				nxt_out_d = s_in.beat;
			end else begin
				nxt_out_v = 1'b0;
			end
		end else if (take) begin
			if (!out_v_ff) begin
				nxt_out_v = 1'b1;
				nxt_out_d = s_in.beat;
			end else begin
				nxt_sk_v = 1'b1;
				nxt_sk_d = s_in.beat;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			out_v_ff <= 1'b0;
			sk_v_ff  <= 1'b0;
			out_d_ff <= '0;
			sk_d_ff  <= '0;
		end else begin
			out_v_ff <= nxt_out_v;
			sk_v_ff  <= nxt_sk_v;
			out_d_ff <= nxt_out_d;
			sk_d_ff  <= nxt_sk_d;
		end
	end
endmodule
`default_nettype wire

/* File: ptg_pkg.sv */
package ptg_pkg;

	// ----------------------------------------------------------------
	// indirect access port
	// ----------------------------------------------------------------
	localparam logic [1:0] ACC_SEL_BLOCK  = 2'h0;
	localparam logic [1:0] ACC_SEL_OFFSET = 2'h1;
	localparam logic [1:0] ACC_SEL_DATA   = 2'h2;
	localparam int         BSEL_AUTOINC   = 1;
	localparam int         BSEL_BLK_LSB   = 2;
	localparam int         BSEL_BLK_MSB   = 5;
	localparam logic [3:0] BLOCK_PATTERN  = 4'h0;

	// ----------------------------------------------------------------
	// register offsets on the pattern page
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTL     = 8'h01;
	localparam logic [7:0] OFF_CFG     = 8'h02;
	localparam logic [7:0] OFF_HDR     = 8'h03;
	localparam logic [7:0] OFF_LINE_HI = 8'h04;
	localparam logic [7:0] OFF_LINE_LO = 8'h05;
	localparam logic [7:0] OFF_BAR_HI  = 8'h06;
	localparam logic [7:0] OFF_BAR_LO  = 8'h07;
	localparam logic [7:0] OFF_ACT_HI  = 8'h08;
	localparam logic [7:0] OFF_ACT_LO  = 8'h09;
	localparam logic [7:0] OFF_TOT_HI  = 8'h0A;
	localparam logic [7:0] OFF_TOT_LO  = 8'h0B;
	localparam logic [7:0] OFF_LPD_HI  = 8'h0C;
	localparam logic [7:0] OFF_LPD_LO  = 8'h0D;
	localparam logic [7:0] OFF_VBP     = 8'h0E;
	localparam int         NUM_REGS    = 15;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTL_ON_BIT    = 0;
	localparam int CFG_SOLID_BIT = 7;
	localparam int CFG_BARS_MSB  = 5;
	localparam int CFG_BARS_LSB  = 4;
	localparam int CFG_BLK_MSB   = 3;
	localparam int CFG_BLK_LSB   = 0;
	localparam int HDR_VC_MSB    = 7;
	localparam int HDR_VC_LSB    = 6;
	localparam int HDR_DT_MSB    = 5;
	localparam int HDR_DT_LSB    = 0;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CTL     = 8'h00;
	localparam logic [7:0] RST_CFG     = 8'h33;
	localparam logic [7:0] RST_HDR     = 8'h24;
	localparam logic [7:0] RST_LINE_HI = 8'h07;
	localparam logic [7:0] RST_LINE_LO = 8'h80;
	localparam logic [7:0] RST_BAR_HI  = 8'h00;
	localparam logic [7:0] RST_BAR_LO  = 8'hF0;
	localparam logic [7:0] RST_ACT_HI  = 8'h01;
	localparam logic [7:0] RST_ACT_LO  = 8'hE0;
	localparam logic [7:0] RST_TOT_HI  = 8'h02;
	localparam logic [7:0] RST_TOT_LO  = 8'h0D;
	localparam logic [7:0] RST_LPD_HI  = 8'h0C;
	localparam logic [7:0] RST_LPD_LO  = 8'h67;
	localparam logic [7:0] RST_VBP     = 8'h02;
	localparam logic [7:0] RST_UNUSED  = 8'h00;

	localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {
		RST_VBP, RST_LPD_LO, RST_LPD_HI, RST_TOT_LO, RST_TOT_HI,
		RST_ACT_LO, RST_ACT_HI, RST_BAR_LO, RST_BAR_HI, RST_LINE_LO,
		RST_LINE_HI, RST_HDR, RST_CFG, RST_CTL, RST_UNUSED};

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int TICK_NS       = 10;
	localparam int CLK_PERIOD_NS = 100;
	localparam int TICKS_PER_CLK = CLK_PERIOD_NS / TICK_NS;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {PKT_FS, PKT_FE, PKT_LINE} ptg_kind_t;

	typedef struct packed {
		ptg_kind_t   kind;
		logic [7:0]  data;
		logic        last;
		logic [1:0]  vc;
		logic [5:0]  dt;
	} ptg_beat_t;

	typedef struct packed {
		logic [15:0] line_len;
		logic [15:0] bar_w;
		logic [15:0] act;
		logic [15:0] tot;
		logic [15:0] period;
		logic [7:0]  vbp;
		logic        solid;
		logic [1:0]  bars;
		logic [3:0]  blk;
		logic [1:0]  vc;
		logic [5:0]  dt;
	} ptg_frame_cfg_t;

endpackage

/* File: ptg_sink_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ptg_sink_model (
	input  wire logic               i_core_clk,
	input  wire logic               i_rst,
	input  wire logic               i_slow,
	input  wire logic               i_valid,
	input  wire ptg_pkg::ptg_beat_t i_beat,
	output var  logic               o_ready
);
	// ----------------------------------------------------------------
	// beat capture
	// ----------------------------------------------------------------
	ptg_pkg::ptg_beat_t beats[$];
	int                 stamp[$];
	int                 cyc = 0;
	// slow mode takes one beat in four, so the buffer fills
	always @(posedge i_core_clk) begin
		if (i_valid && o_ready && !i_rst) begin
			beats.push_back(i_beat);
			stamp.push_back(cyc);
		end
		cyc = cyc + 1;
		o_ready <= #1 !i_slow || cyc[1:0] == 2'h0;
	end
endmodule
`default_nettype wire

/* File: ptg_strm_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ptg_strm_if;
	logic                valid;
	logic                ready;
	ptg_pkg::ptg_beat_t  beat;
	modport src (output valid, output beat, input ready);
	modport dst (input valid, input beat, output ready);
endinterface
`default_nettype wire

/* File: ptg_top.sv */
// What this block does
// - Frames are generated only while pattern_gen_on is 1; writing 0 stops them.
// - solid_pattern_select 1 gives fixed color fields, 0 gives color bars.
// - bar_count_code 00/01/10/11 gives 1/2/4/8 bars; resets to 3.
// - In fixed mode each color field is solid-field-bytes long, 1 to 15.
// - Every packet carries packet_virtual_channel from header bits 7:6.
// - Every packet carries packet_data_type from bits 5:0, reset 0x24.
// - Each active line holds exactly active_line_bytes bytes, reset 1920.
// - All bars but the last are exactly bar_width_bytes long, or 1 byte when it is 0.
// - The last bar fills the rest of the active line.
// - A frame holds active_lines_per_frame video lines, reset 480.
// - Frame length equals total_lines_per_frame, blanking included.
// - Successive lines are spaced by line_period_ticks in 10 ns units, rounded up to whole clocks, plus one clock.
// - vertical_back_porch_lines blank lines lie between frame start and first data.
// - Indirect port selects block and offset; auto-increment advances offset per data access.
`timescale 1ns/1ps
`default_nettype none
module ptg_top (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire logic        i_acc_wr,
	input  wire logic        i_acc_rd,
	input  wire logic [1:0]  i_acc_sel,
	input  wire logic [7:0]  i_acc_wdata,
	output var  logic [7:0]  o_acc_rdata,
	output var  logic        o_acc_rvalid,
	output var  logic        o_busy,
	output var  logic        o_tx_valid,
	input  wire logic        i_tx_ready,
	output var  logic [1:0]  o_tx_kind,
	output var  logic [7:0]  o_tx_data,
	output var  logic        o_tx_last,
	output var  logic [1:0]  o_tx_vc,
	output var  logic [5:0]  o_tx_dt
);
	typedef enum logic [2:0] {S_IDLE, S_FS, S_DATA, S_FE, S_WAIT} ptg_state_t;

	// ----------------------------------------------------------------
	// indirect register access
	// ----------------------------------------------------------------
	logic [ptg_pkg::NUM_REGS-1:0][7:0] regs_ff;
	logic [ptg_pkg::NUM_REGS-1:0][7:0] nxt_regs;
	logic [7:0]                        bsel_ff;
	logic [7:0]                        nxt_bsel;
	logic [7:0]                        off_ff;
	logic [7:0]                        nxt_off;
	logic [7:0]                        rdata_ff;
	logic [7:0]                        nxt_rdata;
	logic                              rvalid_ff;
	logic                              nxt_rvalid;
	logic                              hit;
	logic                              data_acc;

	// only page 0 offsets 0x01..0x0E exist; offset 0 and the rest read zero
	assign hit = (bsel_ff[ptg_pkg::BSEL_BLK_MSB:ptg_pkg::BSEL_BLK_LSB] == ptg_pkg::BLOCK_PATTERN)
		&& (off_ff >= ptg_pkg::OFF_CTL) && (off_ff <= ptg_pkg::OFF_VBP);
	assign data_acc = (i_acc_wr | i_acc_rd) && (i_acc_sel == ptg_pkg::ACC_SEL_DATA);

	always_comb begin
		nxt_regs   = regs_ff;
		nxt_bsel   = bsel_ff;
		nxt_off    = off_ff;
		nxt_rdata  = rdata_ff;
		nxt_rvalid = i_acc_rd;
		if (i_acc_wr) begin
			case (i_acc_sel)
				ptg_pkg::ACC_SEL_BLOCK: begin
					nxt_bsel = i_acc_wdata;
				end
				ptg_pkg::ACC_SEL_OFFSET: begin
					nxt_off = i_acc_wdata;
				end
				ptg_pkg::ACC_SEL_DATA: begin
					if (hit) begin
						nxt_regs[off_ff[3:0]] = i_acc_wdata;
					end
				end
				default: begin
				end
			endcase
		end
		if (i_acc_rd) begin
			case (i_acc_sel)
				ptg_pkg::ACC_SEL_BLOCK:  nxt_rdata = bsel_ff;
				ptg_pkg::ACC_SEL_OFFSET: nxt_rdata = off_ff;
				ptg_pkg::ACC_SEL_DATA:   nxt_rdata = hit ? regs_ff[off_ff[3:0]] : 8'h00;
				default:                 nxt_rdata = 8'h00;
			endcase
		end
		// an offset write in the same cycle wins over the increment
		if (data_acc && bsel_ff[ptg_pkg::BSEL_AUTOINC]
			&& !(i_acc_wr && i_acc_sel == ptg_pkg::ACC_SEL_OFFSET)) begin
			nxt_off = off_ff + 8'h01;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			regs_ff   <= ptg_pkg::REG_RESET;
			bsel_ff   <= 8'h00;
			off_ff    <= 8'h00;
			rdata_ff  <= 8'h00;
			rvalid_ff <= 1'b0;
		end else begin
			regs_ff   <= nxt_regs;
			bsel_ff   <= nxt_bsel;
			off_ff    <= nxt_off;
			rdata_ff  <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	// ----------------------------------------------------------------
	// live settings, high byte above low byte
	// ----------------------------------------------------------------
	ptg_pkg::ptg_frame_cfg_t cur_cfg;
	logic                    gen_on;
	logic [7:0]              cfg_b;
	logic [7:0]              hdr_b;

	assign gen_on = regs_ff[ptg_pkg::OFF_CTL[3:0]][ptg_pkg::CTL_ON_BIT];
	assign cfg_b  = regs_ff[ptg_pkg::OFF_CFG[3:0]];
	assign hdr_b  = regs_ff[ptg_pkg::OFF_HDR[3:0]];

	always_comb begin
		cur_cfg.line_len = {regs_ff[ptg_pkg::OFF_LINE_HI[3:0]], regs_ff[ptg_pkg::OFF_LINE_LO[3:0]]};
		cur_cfg.bar_w    = {regs_ff[ptg_pkg::OFF_BAR_HI[3:0]], regs_ff[ptg_pkg::OFF_BAR_LO[3:0]]};
		cur_cfg.act      = {regs_ff[ptg_pkg::OFF_ACT_HI[3:0]], regs_ff[ptg_pkg::OFF_ACT_LO[3:0]]};
		cur_cfg.tot      = {regs_ff[ptg_pkg::OFF_TOT_HI[3:0]], regs_ff[ptg_pkg::OFF_TOT_LO[3:0]]};
		cur_cfg.period   = {regs_ff[ptg_pkg::OFF_LPD_HI[3:0]], regs_ff[ptg_pkg::OFF_LPD_LO[3:0]]};
		cur_cfg.vbp      = regs_ff[ptg_pkg::OFF_VBP[3:0]];
		cur_cfg.solid    = cfg_b[ptg_pkg::CFG_SOLID_BIT];
		cur_cfg.bars     = cfg_b[ptg_pkg::CFG_BARS_MSB:ptg_pkg::CFG_BARS_LSB];
		cur_cfg.blk      = cfg_b[ptg_pkg::CFG_BLK_MSB:ptg_pkg::CFG_BLK_LSB];
		cur_cfg.vc       = hdr_b[ptg_pkg::HDR_VC_MSB:ptg_pkg::HDR_VC_LSB];
		cur_cfg.dt       = hdr_b[ptg_pkg::HDR_DT_MSB:ptg_pkg::HDR_DT_LSB];
	end

	// ----------------------------------------------------------------
	// frame and line sequencer
	// ----------------------------------------------------------------
	function automatic ptg_state_t enter_line(input logic [16:0] lno, input ptg_pkg::ptg_frame_cfg_t c);
		logic [16:0] act_end;
		logic        in_act;
		act_end = 17'(c.vbp) + 17'(c.act);
		in_act  = (lno >= 17'(c.vbp)) && (lno < act_end);
		if (in_act && c.line_len != 16'h0000) begin
			enter_line = S_DATA;
		end else if (in_act && lno + 17'h00001 == act_end) begin
			enter_line = S_FE;
		end else begin
			enter_line = S_WAIT;
		end
	endfunction

	ptg_strm_if g ();
	ptg_strm_if q ();

	ptg_state_t              st_ff;
	ptg_state_t              nxt_st;
	ptg_pkg::ptg_frame_cfg_t sh_ff;
	ptg_pkg::ptg_frame_cfg_t nxt_sh;
	logic [15:0]             line_ff;
	logic [15:0]             nxt_line;
	logic [15:0]             timer_ff;
	logic [15:0]             nxt_timer;
	logic [15:0]             byte_ff;
	logic [15:0]             nxt_byte;
	logic [15:0]             bpos_ff;
	logic [15:0]             nxt_bpos;
	logic [2:0]              bidx_ff;
	logic [2:0]              nxt_bidx;
	logic [1:0]              phase_ff;
	logic [1:0]              nxt_phase;
	logic [3:0]              fpos_ff;
	logic [3:0]              nxt_fpos;
	logic [2:0]              fld_ff;
	logic [2:0]              nxt_fld;
	logic                    fe_due_ff;
	logic                    nxt_fe_due;
	logic                    busy_ff;
	logic [16:0]             tsum;
	logic                    tdone;
	logic [16:0]             next_line;
	logic                    frame_over;
	logic [2:0]              last_bar;
	logic [3:0]              blk_eff;
	logic [2:0]              cidx;
	logic                    comp;
	logic                    last_byte;

	assign tsum       = {1'b0, timer_ff} + 17'(ptg_pkg::TICKS_PER_CLK);
	assign tdone      = timer_ff >= sh_ff.period;
	assign next_line  = {1'b0, line_ff} + 17'h00001;
	assign frame_over = next_line >= {1'b0, sh_ff.tot};
	assign last_bar   = 3'((4'h1 << sh_ff.bars) - 4'h1);
	// a field size of zero acts as one, which the compare below would also give, since fpos + 1 >= 0 always holds
	assign blk_eff    = (sh_ff.blk == 4'h0) ? 4'h1 : sh_ff.blk;
	assign cidx       = sh_ff.solid ? fld_ff : 3'(bidx_ff << (2'h3 - sh_ff.bars));
	assign comp       = (phase_ff == 2'h0) ? ~cidx[2] : (phase_ff == 2'h1) ? ~cidx[1] : ~cidx[0];
	assign last_byte  = byte_ff + 16'h0001 == sh_ff.line_len;

	assign g.valid     = (st_ff == S_FS) || (st_ff == S_DATA) || (st_ff == S_FE);
	assign g.beat.kind = (st_ff == S_FS) ? ptg_pkg::PKT_FS : (st_ff == S_FE) ? ptg_pkg::PKT_FE : ptg_pkg::PKT_LINE;
	assign g.beat.data = (st_ff == S_DATA) ? (comp ? 8'hFF : 8'h00) : 8'h00;
	assign g.beat.last = (st_ff != S_DATA) || last_byte;
	assign g.beat.vc   = sh_ff.vc;
	assign g.beat.dt   = sh_ff.dt;

	always_comb begin
		nxt_st     = st_ff;
		nxt_sh     = sh_ff;
		nxt_line   = line_ff;
		nxt_timer  = (tsum > {1'b0, sh_ff.period}) ? sh_ff.period : tsum[15:0];
		nxt_fe_due = fe_due_ff;
		nxt_byte   = 16'h0000;
		nxt_bpos   = 16'h0000;
		nxt_bidx   = 3'h0;
		nxt_phase  = 2'h0;
		nxt_fpos   = 4'h0;
		nxt_fld    = 3'h0;
		case (st_ff)
			S_IDLE: begin
				nxt_timer = 16'h0000;
				if (gen_on) begin
					nxt_sh     = cur_cfg;
					nxt_line   = 16'h0000;
					nxt_fe_due = 1'b1;
					nxt_st     = S_FS;
				end
			end
			S_FS: begin
				if (g.ready) begin
					nxt_st = enter_line(17'h00000, sh_ff);
				end
			end
			S_DATA: begin
				nxt_byte  = byte_ff;
				nxt_bpos  = bpos_ff;
				nxt_bidx  = bidx_ff;
				nxt_phase = phase_ff;
				nxt_fpos  = fpos_ff;
				nxt_fld   = fld_ff;
				if (g.ready) begin
					nxt_byte  = byte_ff + 16'h0001;
					nxt_phase = (phase_ff == 2'h2) ? 2'h0 : phase_ff + 2'h1;
					// the last bar never advances, so it absorbs the remainder
					if (bidx_ff != last_bar && bpos_ff + 16'h0001 >= sh_ff.bar_w) begin
						nxt_bidx = bidx_ff + 3'h1;
						nxt_bpos = 16'h0000;
					end else begin
						nxt_bpos = bpos_ff + 16'h0001;
					end
					if (fpos_ff + 4'h1 >= blk_eff) begin
						nxt_fld  = fld_ff + 3'h1;
						nxt_fpos = 4'h0;
					end else begin
						nxt_fpos = fpos_ff + 4'h1;
					end
					if (last_byte) begin
						nxt_st = (next_line == 17'(sh_ff.vbp) + 17'(sh_ff.act)) ? S_FE : S_WAIT;
					end
				end
			end
			S_FE: begin
				if (g.ready) begin
					nxt_fe_due = 1'b0;
					nxt_st     = S_WAIT;
				end
			end
			S_WAIT: begin
				if (fe_due_ff && (!gen_on || (tdone && frame_over))) begin
					nxt_st = S_FE;
				end else if (!gen_on) begin
					nxt_st = S_IDLE;
				end else if (tdone) begin
					nxt_timer = 16'h0000;
					if (frame_over) begin
						nxt_sh     = cur_cfg;
						nxt_line   = 16'h0000;
						nxt_fe_due = 1'b1;
						nxt_st     = S_FS;
					end else begin
						nxt_line = next_line[15:0];
						nxt_st   = enter_line(next_line, sh_ff);
					end
				end
			end
			default: begin
				nxt_st = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_ff     <= S_IDLE;
			sh_ff     <= '0;
			line_ff   <= 16'h0000;
			timer_ff  <= 16'h0000;
			byte_ff   <= 16'h0000;
			bpos_ff   <= 16'h0000;
			bidx_ff   <= 3'h0;
			phase_ff  <= 2'h0;
			fpos_ff   <= 4'h0;
			fld_ff    <= 3'h0;
			fe_due_ff <= 1'b0;
			busy_ff   <= 1'b0;
		end else begin
			st_ff     <= nxt_st;
			sh_ff     <= nxt_sh;
			line_ff   <= nxt_line;
			timer_ff  <= nxt_timer;
			byte_ff   <= nxt_byte;
			bpos_ff   <= nxt_bpos;
			bidx_ff   <= nxt_bidx;
			phase_ff  <= nxt_phase;
			fpos_ff   <= nxt_fpos;
			fld_ff    <= nxt_fld;
			fe_due_ff <= nxt_fe_due;
			busy_ff   <= nxt_st != S_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// output buffer; a receiver stall only holds the sequencer
	// ----------------------------------------------------------------
	ptg_buf2 u_buf (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.s_in       (g.dst),
		.s_out      (q.src)
	);

	assign q.ready      = i_tx_ready;
	assign o_tx_valid   = q.valid;
	assign o_tx_kind    = q.beat.kind;
	assign o_tx_data    = q.beat.data;
	assign o_tx_last    = q.beat.last;
	assign o_tx_vc      = q.beat.vc;
	assign o_tx_dt      = q.beat.dt;
	assign o_acc_rdata  = rdata_ff;
	assign o_acc_rvalid = rvalid_ff;
	assign o_busy       = busy_ff;
endmodule
`default_nettype wire

/* File: ptg_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module ptg_top_asserts (
	input  wire logic       i_core_clk,
	input  wire logic       i_rst,
	input  wire logic       i_acc_wr,
	input  wire logic       i_acc_rd,
	input  wire logic [1:0] i_acc_sel,
	input  wire logic [7:0] i_acc_wdata,
	input  wire logic [7:0] o_acc_rdata,
	input  wire logic       o_acc_rvalid,
	input  wire logic       o_busy,
	input  wire logic       o_tx_valid,
	input  wire logic       i_tx_ready,
	input  wire logic [1:0] o_tx_kind,
	input  wire logic [7:0] o_tx_data,
	input  wire logic       o_tx_last,
	input  wire logic [1:0] o_tx_vc,
	input  wire logic [5:0] o_tx_dt
);
	// ----------------------------------------------------------------
	// frame tracking
	// ----------------------------------------------------------------
	logic       frm_ff;
	logic       nxt_frm;
	logic [7:0] hdr_ff;
	logic [7:0] nxt_hdr;
	logic       take;
	assign take = o_tx_valid && i_tx_ready;
	always_comb begin
		nxt_frm = frm_ff;
		nxt_hdr = hdr_ff;
		if (take && o_tx_kind == ptg_pkg::PKT_FS) begin
			nxt_frm = 1'b1;
			nxt_hdr = {o_tx_vc, o_tx_dt};
		end else if (take && o_tx_kind == ptg_pkg::PKT_FE) begin
			nxt_frm = 1'b0;
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			frm_ff <= 1'b0;
			hdr_ff <= 8'h00;
		end else begin
			frm_ff <= nxt_frm;
			hdr_ff <= nxt_hdr;
		end
	end
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);
	hold_on_stall_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable({o_tx_kind, o_tx_data}))
		else $error("beat changed while stalled");
	read_answer_a: assert property (i_acc_rd |=> o_acc_rvalid)
		else $error("read not answered next cycle");
	answer_cause_a: assert property (o_acc_rvalid |-> $past(i_acc_rd))
		else $error("read answer without read");
	rdata_hold_a: assert property (!o_acc_rvalid |-> $stable(o_acc_rdata))
		else $error("read data moved without answer");
	ctrl_beat_a: assert property (o_tx_valid && o_tx_kind != ptg_pkg::PKT_LINE |-> o_tx_last && o_tx_data == 8'h00)
		else $error("frame marker beat malformed");
	color_byte_a: assert property (o_tx_valid && o_tx_kind == ptg_pkg::PKT_LINE |-> o_tx_data inside {8'h00, 8'hFF})
		else $error("pixel byte not full or empty");
	start_outside_a: assert property (take && o_tx_kind == ptg_pkg::PKT_FS |-> !frm_ff)
		else $error("frame start inside frame");
	line_inside_a: assert property (take && o_tx_kind == ptg_pkg::PKT_LINE |-> frm_ff)
		else $error("line data outside frame");
	header_kept_a: assert property (take && o_tx_kind != ptg_pkg::PKT_FS |-> {o_tx_vc, o_tx_dt} == hdr_ff)
		else $error("packet header changed within frame");
	cover property (take && o_tx_kind == ptg_pkg::PKT_FE);
	cover property (o_tx_valid && !i_tx_ready);
	cover property (o_acc_rvalid);
endmodule
`default_nettype wire

/* File: test_ptg_top.sv */
`timescale 1ns/1ps
`default_nettype none
module test_ptg_top;
	localparam int         ACT = 2;
	localparam int         TOT = 4;
	localparam int         VBP = 1;
	localparam int         SLOT = 21;
	localparam logic [7:0] HDR = 8'hAA;
	localparam logic [7:0] RST_ROWS [16] = '{8'h00, 8'h00, 8'h33, 8'h24, 8'h07, 8'h80, 8'h00, 8'hF0,
		8'h01, 8'hE0, 8'h02, 8'h0D, 8'h0C, 8'h67, 8'h02, 8'h00};
	// cfg, line bytes, bar bytes
	localparam logic [23:0] ROWS [7] = '{24'h030902, 24'h130902, 24'h230902, 24'h330901, 24'h330900,
		24'h820902, 24'h8F1102};
	logic               clk = 1'b0;
	logic               rst = 1'b1;
	logic               wr = 1'b0;
	logic               rd = 1'b0;
	logic [1:0]         sel = 2'h0;
	logic [7:0]         wd = 8'h00;
	logic [7:0]         rdata;
	logic               rvalid;
	logic               busy;
	logic               tv;
	logic               tr;
	logic [1:0]         kind;
	logic [7:0]         data;
	logic               last;
	logic [1:0]         vc;
	logic [5:0]         dt;
	logic               slow = 1'b0;
	logic [7:0]         cfg;
	ptg_pkg::ptg_beat_t beat;
	int                 n_errors = 0;
	int                 n_compared = 0;
	int                 cyc = 0;
	int                 line_len;
	int                 bar_w;
	int                 base;
	assign beat = {kind, data, last, vc, dt};
	initial forever #50 clk = ~clk;
	ptg_top ptg_top_inst (.i_core_clk(clk), .i_rst(rst), .i_acc_wr(wr), .i_acc_rd(rd), .i_acc_sel(sel),
		.i_acc_wdata(wd), .o_acc_rdata(rdata), .o_acc_rvalid(rvalid), .o_busy(busy), .o_tx_valid(tv),
		.i_tx_ready(tr), .o_tx_kind(kind), .o_tx_data(data), .o_tx_last(last), .o_tx_vc(vc), .o_tx_dt(dt));
	ptg_sink_model ptg_sink_model_inst (.i_core_clk(clk), .i_rst(rst), .i_slow(slow), .i_valid(tv),
		.i_beat(beat), .o_ready(tr));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_num(input int got, input int lo, input int hi);
		n_compared++;
		if (got < lo || got > hi) begin
			n_errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, lo);
		end
	endtask
	task automatic acc(input logic w, input logic [1:0] s, input logic [7:0] d);
		@(posedge clk);
		#1;
		wr = w;
		rd = !w;
		sel = s;
		wd = d;
		@(posedge clk);
		#1;
		wr = 1'b0;
		rd = 1'b0;
	endtask
	task automatic wreg(input logic [7:0] off, input logic [7:0] d);
		acc(1'b1, ptg_pkg::ACC_SEL_OFFSET, off);
		acc(1'b1, ptg_pkg::ACC_SEL_DATA, d);
	endtask
	task automatic rchk(input logic [7:0] exp);
		acc(1'b0, ptg_pkg::ACC_SEL_DATA, 8'h00);
		cmp_val({15'h0000, rvalid}, 16'h0001);
		cmp_val({8'h00, rdata}, {8'h00, exp});
	endtask
	function automatic logic [7:0] exp_byte(input int i);
		int k;
		int c;
		if (cfg[7]) begin
			c = (i / ((cfg[3:0] == 4'h0) ? 1 : int'(cfg[3:0]))) % 8;
		end else begin
			k = (bar_w == 0) ? i : i / bar_w;
			if (k > (1 << cfg[5:4]) - 1)
				k = (1 << cfg[5:4]) - 1;
			c = k << (3 - cfg[5:4]);
		end
		return c[2 - (i % 3)] ? 8'h00 : 8'hFF;
	endfunction
	task automatic check_frame();
		ptg_pkg::ptg_beat_t b;
		int                 e;
		e = base + 1 + ACT * line_len;
		cmp_val(16'(ptg_sink_model_inst.beats[base].kind), 16'(ptg_pkg::PKT_FS));
		for (int l = 0; l < ACT; l++) begin
			for (int i = 0; i < line_len; i++) begin
				b = ptg_sink_model_inst.beats[base + 1 + l * line_len + i];
				cmp_val(16'(b.data), 16'(exp_byte(i)));
				cmp_val(16'({b.kind, b.last, b.vc, b.dt}), 16'({ptg_pkg::PKT_LINE, i == line_len - 1, HDR}));
			end
		end
		cmp_val(16'(ptg_sink_model_inst.beats[e].kind), 16'(ptg_pkg::PKT_FE));
		cmp_val(16'(ptg_sink_model_inst.beats[e + 1].kind), 16'(ptg_pkg::PKT_FS));
		if (!slow) begin
			cmp_num(ptg_sink_model_inst.stamp[e + 1] - ptg_sink_model_inst.stamp[base], TOT * SLOT, TOT * SLOT);
			cmp_num(ptg_sink_model_inst.stamp[base + 1] - ptg_sink_model_inst.stamp[base], VBP * SLOT, VBP * SLOT + 4);
			cmp_num(ptg_sink_model_inst.stamp[base + 1 + line_len] - ptg_sink_model_inst.stamp[base + 1], SLOT, SLOT);
		end
	endtask
	// a full frame plus the next start, then stop and let the buffer drain
	task automatic run_frame(input logic [23:0] row, input logic s);
		cfg = row[23:16];
		line_len = row[15:8];
		bar_w = row[7:0];
		slow = s;
		wreg(ptg_pkg::OFF_CFG, cfg);
		wreg(ptg_pkg::OFF_LINE_HI, 8'h00);
		wreg(ptg_pkg::OFF_LINE_LO, row[15:8]);
		wreg(ptg_pkg::OFF_BAR_HI, 8'h00);
		wreg(ptg_pkg::OFF_BAR_LO, row[7:0]);
		base = ptg_sink_model_inst.beats.size();
		wreg(ptg_pkg::OFF_CTL, 8'h01);
		while (ptg_sink_model_inst.beats.size() < base + ACT * line_len + 3)
			@(posedge clk);
		wreg(ptg_pkg::OFF_CTL, 8'h00);
		while (busy !== 1'b0 || tv !== 1'b0)
			@(posedge clk);
		check_frame();
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		acc(1'b1, ptg_pkg::ACC_SEL_BLOCK, 8'h02);
		acc(1'b1, ptg_pkg::ACC_SEL_OFFSET, 8'h00);
		acc(1'b0, ptg_pkg::ACC_SEL_BLOCK, 8'h00);
		cmp_val({8'h00, rdata}, 16'h0002);
		foreach (RST_ROWS[i]) rchk(RST_ROWS[i]);
		wreg(ptg_pkg::OFF_HDR, HDR);
		wreg(ptg_pkg::OFF_ACT_HI, 8'h00);
		wreg(ptg_pkg::OFF_ACT_LO, 8'(ACT));
		wreg(ptg_pkg::OFF_TOT_HI, 8'h00);
		wreg(ptg_pkg::OFF_TOT_LO, 8'(TOT));
		wreg(ptg_pkg::OFF_LPD_HI, 8'h00);
		wreg(ptg_pkg::OFF_LPD_LO, 8'hC8);
		wreg(ptg_pkg::OFF_VBP, 8'(VBP));
		foreach (ROWS[i]) run_frame(ROWS[i], 1'b0);
		run_frame(24'h130902, 1'b1);
		acc(1'b1, ptg_pkg::ACC_SEL_BLOCK, 8'h06);
		wreg(ptg_pkg::OFF_CFG, 8'h00);
		acc(1'b1, ptg_pkg::ACC_SEL_BLOCK, 8'h02);
		acc(1'b1, ptg_pkg::ACC_SEL_OFFSET, ptg_pkg::OFF_CFG);
		rchk(8'h13);
		acc(1'b1, ptg_pkg::ACC_SEL_OFFSET, 8'h0F);
		rchk(8'h00);
		wreg(ptg_pkg::OFF_CTL, 8'h01);
		repeat (30) @(posedge clk);
		#1;
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		cmp_val({14'h0000, tv, busy}, 16'h0000);
		base = ptg_sink_model_inst.beats.size();
		repeat (30) @(posedge clk);
		cmp_num(ptg_sink_model_inst.beats.size(), base, base);
		acc(1'b1, ptg_pkg::ACC_SEL_BLOCK, 8'h02);
		acc(1'b1, ptg_pkg::ACC_SEL_OFFSET, ptg_pkg::OFF_CTL);
		rchk(8'h00);
		tally_and_finish();
	end
endmodule
bind ptg_top ptg_top_asserts ptg_top_asserts_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_acc_wr(i_acc_wr),
	.i_acc_rd(i_acc_rd), .i_acc_sel(i_acc_sel), .i_acc_wdata(i_acc_wdata), .o_acc_rdata(o_acc_rdata),
	.o_acc_rvalid(o_acc_rvalid), .o_busy(o_busy), .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready),
	.o_tx_kind(o_tx_kind), .o_tx_data(o_tx_data), .o_tx_last(o_tx_last), .o_tx_vc(o_tx_vc), .o_tx_dt(o_tx_dt));
`default_nettype wire
